/* File: src/host_control_port.sv */
// multiplexed 8-bit host control port with its 64-byte register bank
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defines.svh"

module host_control_port #(
  parameter int WIDTH         = `HP_BUS_WIDTH,
  parameter int REGS          = `HP_REG_COUNT,
  parameter int STUCK_CYCLES  = `HP_STUCK_HIGH_CYCLES
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // shared address/data bus, split into three signals
  input  wire logic [WIDTH-1:0]         ad_in,
  output logic      [WIDTH-1:0]         ad_out,
  output logic                          ad_oe,
  // strobes and select
  input  wire logic                     chip_select_n,
  input  wire logic                     read_or_data_strobe,
  input  wire logic                     address_capture_strobe,
  input  wire logic                     write_or_read_not_write,
  // strap and backplane clock watch
  input  wire logic                     bus_style_select,
  input  wire logic                     backplane_clock_in,
  output logic                          outputs_float
);

  import host_port_pkg::*;

  localparam int IDX_W = $clog2(REGS);
  localparam int CNT_W = $clog2(STUCK_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(STUCK_CYCLES);

  // low address bits pick the register; upper bits are don't-care
  function automatic logic [IDX_W-1:0] reg_index(
    input logic [WIDTH-1:0] address
  );
    reg_index = address[IDX_W-1:0];
  endfunction

  bus_style_type              bus_style;
  logic                       strap_taken;
  logic                       prev_capture;
  logic [WIDTH-1:0]           address;
  logic [WIDTH-1:0]           write_hold;
  access_phase_type           phase;
  access_phase_type           next_phase;
  logic [CNT_W-1:0]           high_count;
  logic [WIDTH-1:0]           bank_data;

  wire capture_rise;
  wire strobe_on;
  wire want_read;
  wire want_write;
  wire commit_write;
  wire stuck_high;

  // strap is caught once, on the first edge after reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_style   <= STYLE_SEPARATE;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      bus_style   <= bus_style_type'(bus_style_select); // RL5
      strap_taken <= 1'b1;
    end
  end

  // strobe decode for the two timing styles
  assign strobe_on = (bus_style == STYLE_DATA_STROBE) ?
                     read_or_data_strobe : !read_or_data_strobe; // RL5
  assign want_read = !chip_select_n && strobe_on &&
                     ((bus_style == STYLE_DATA_STROBE) ?
                      write_or_read_not_write : 1'b1); // RL2 RL5
  assign want_write = !chip_select_n &&
                      ((bus_style == STYLE_DATA_STROBE) ?
                       (strobe_on && !write_or_read_not_write) :
                       !write_or_read_not_write); // RL2 RL5
  assign capture_rise = address_capture_strobe && !prev_capture; // RL3

  // address phase: latch on the rising edge of the capture strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_capture <= 1'b0;
      address      <= WIDTH'(`HP_BYTE_RESET);
    end else begin
      prev_capture <= address_capture_strobe;
      if (capture_rise) begin
        address <= ad_in; // RL1 RL3
      end
    end
  end

  // access phase tracking; a write lands when its strobe ends
  always_comb begin
    next_phase = PHASE_IDLE;
    case (phase)
      PHASE_IDLE,
      PHASE_READ,
      PHASE_WRITE: begin
        if (want_write) begin
          next_phase = PHASE_WRITE;
        end else if (want_read) begin
          next_phase = PHASE_READ;
        end
      end
      default: begin
        next_phase = PHASE_IDLE;
      end
    endcase
  end

  assign commit_write = (phase == PHASE_WRITE) && !want_write; // RL4

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase      <= PHASE_IDLE;
      write_hold <= WIDTH'(`HP_BYTE_RESET);
    end else begin
      phase <= next_phase;
      if (want_write) begin
        write_hold <= ad_in; // RL1
      end
    end
  end

  // stuck-high watch on the backplane clock, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_count <= '0;
    end else if (!backplane_clock_in) begin
      high_count <= '0;
    end else if (high_count != CNT_LIMIT) begin
      high_count <= high_count + CNT_W'(1); // RL6
    end
  end

  assign stuck_high = (high_count == CNT_LIMIT); // RL6

  register_bank #(
    .WIDTH  (WIDTH),
    .DEPTH  (REGS),
    .ADDR_W (IDX_W)
  ) bank (
    .clk         (clk),
    .rst_n       (rst_n),
    .write_en    (commit_write),
    .write_index (reg_index(address)), // RL7
    .write_data  (write_hold),
    .read_index  (reg_index(address)), // RL7
    .read_data   (bank_data)
  );

  // the bus is driven only inside a selected read, never while floated
  assign ad_out        = bank_data;
  assign ad_oe         = want_read && !stuck_high; // RL7 RL6
  assign outputs_float = stuck_high; // RL6

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  addr_latch_a: assert property ( // RL3
    capture_rise |=> address == $past(ad_in))
    else $error("address not latched on capture strobe rise");

  select_gate_a: assert property ( // RL2
    chip_select_n |-> !ad_oe && !want_write)
    else $error("port reacted while chip select high");

  bus_share_a: assert property ( // RL1
    (capture_rise && ad_oe) |-> 1'b0)
    else $error("bus driven during address capture");

  read_drive_a: assert property ( // RL7
    ad_oe |-> !chip_select_n && strobe_on && phase != PHASE_WRITE)
    else $error("bus driven outside a read");

  write_land_a: assert property ( // RL4
    (phase == PHASE_WRITE && !want_write) |=>
      $past(write_hold) == write_hold || want_write)
    else $error("write data moved at commit");

  // the clock may already be low on the edge that clears the counter
  float_hold_a: assert property ( // RL6
    outputs_float |-> !ad_oe && high_count == CNT_LIMIT &&
      $past(backplane_clock_in))
    else $error("outputs not floated when clock stuck high");

  float_release_a: assert property ( // RL6
    !backplane_clock_in |=> !outputs_float)
    else $error("float held after clock went low");

  style_stable_a: assert property ( // RL5
    strap_taken |=> $stable(bus_style))
    else $error("bus style changed after strap capture");

endmodule // host_control_port

`default_nettype wire

/* File: inc/host_port_defines.svh */
// bus width, register count, index field positions, reset value and timing counts of the host port
// Functional notes
// RL1 - address then data share one 8-bit bus
// RL2 - strobes ignored while chip select high (the address strobe still latches the address while chip select is high)
// RL3 - address latched on address strobe rising edge
// RL4 - sixty-four byte-wide readable writable registers
// RL5 - strapped style selects strobe pin meanings
// RL6 - backplane clock stuck high floats all outputs
// RL7 - low six address bits select; drive reads only
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define HP_BUS_WIDTH         8
`define HP_REG_COUNT         64
`define HP_INDEX_MSB         5
`define HP_INDEX_LSB         0
`define HP_BYTE_RESET        8'h00
`define HP_CLK_PERIOD_PS     5000
`define HP_STUCK_HIGH_US     100
`define HP_STUCK_HIGH_CYCLES \
  ((`HP_STUCK_HIGH_US * 1000000 + `HP_CLK_PERIOD_PS - 1) / `HP_CLK_PERIOD_PS)

`endif

/* File: inc/host_port_pkg.sv */
// types shared by the host control port files
package host_port_pkg;

  // meaning of the three strobe pins
  typedef enum logic {
    STYLE_SEPARATE,
    STYLE_DATA_STROBE
  } bus_style_type;

  // phase of the current host access
  typedef enum logic [1:0] {
    PHASE_IDLE,
    PHASE_READ,
    PHASE_WRITE
  } access_phase_type;

endpackage

/* File: src/register_bank.sv */
// byte-wide register bank with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defines.svh"

module register_bank #(
  parameter int WIDTH  = `HP_BUS_WIDTH,
  parameter int DEPTH  = `HP_REG_COUNT,
  parameter int ADDR_W = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // write port
  input  wire logic              write_en,
  input  wire logic [ADDR_W-1:0] write_index,
  input  wire logic [WIDTH-1:0]  write_data,
  // read port
  input  wire logic [ADDR_W-1:0] read_index,
  output logic      [WIDTH-1:0]  read_data
);

  logic [WIDTH-1:0] store [DEPTH];

  // contents are not reset; they hold whatever the host last wrote
  always_ff @(posedge clk) begin
    if (write_en) begin
      store[write_index] <= write_data;
    end
  end

  // read data always from a flop so the bus drives a clean value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_data <= WIDTH'(`HP_BYTE_RESET);
    end else begin
      read_data <= store[read_index];
    end
  end

endmodule // register_bank

`default_nettype wire

/* File: tb/host_model.sv */
// host processor model that drives the multiplexed control port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and strap
  input  wire logic       clk,
  input  wire logic       style,
  // pins toward the port
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  output logic      [7:0] ad_in,
  output logic            cs_n,
  output logic            rds,
  output logic            ale,
  output logic            wrw
);
  logic [7:0] drv;
  logic       drv_on;

  // a released bus shows the inverse of the last byte, never a held byte
  assign ad_in = ad_oe ? ad_out : (drv_on ? drv : ~drv);

  task automatic idle();
    cs_n = 1'b1;
    ale = 1'b0;
    rds = ~style;
    wrw = 1'b1;
    drv_on = 1'b0;
  endtask

  // address phase, one idle edge before the data phase
  task automatic addr(input logic [7:0] a);
    @(posedge clk) #1;
    ale = 1'b1;
    drv_on = 1'b1;
    drv = a;
    @(posedge clk) #1;
    ale = 1'b0;
    drv_on = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
    addr(a);
    @(posedge clk) #1;
    cs_n = ~sel;
    drv_on = 1'b1;
    drv = d;
    rds = 1'b1; // read strobe off in style 0, data strobe on in style 1
    wrw = 1'b0;
    @(posedge clk) #1;
    idle();
    @(posedge clk) #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic sel, output logic oe,
                    output logic [7:0] d);
    addr(a);
    @(posedge clk) #1;
    cs_n = ~sel;
    rds = style;
    #3;
    oe = ad_oe;
    d = ad_out;
    @(posedge clk) #1;
    idle();
  endtask
endmodule // host_model
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the host control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk;
  logic       rst_n;
  logic       style;
  logic       bp_clk;
  logic [7:0] ad_in;
  logic [7:0] ad_out;
  logic       ad_oe;
  logic       cs_n;
  logic       rds;
  logic       ale;
  logic       wrw;
  logic       fl;
  logic       oe;
  logic [7:0] d;
  int         bad_count;
  int         comparisons;
  int         cycles;

  // short stuck count keeps the float test brief
  host_control_port #(.STUCK_CYCLES(16)) uut (
    .clk(clk), .rst_n(rst_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .chip_select_n(cs_n), .read_or_data_strobe(rds),
    .address_capture_strobe(ale), .write_or_read_not_write(wrw),
    .bus_style_select(style), .backplane_clock_in(bp_clk),
    .outputs_float(fl)
  );
  host_model host (
    .clk(clk), .style(style), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in),
    .cs_n(cs_n), .rds(rds), .ale(ale), .wrw(wrw)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // a hang costs a mismatch and ends the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // strap must be steady before reset lets go
  task automatic do_reset(input logic s);
    style = s;
    host.idle();
    rst_n = 1'b0;
    @(posedge clk) #1;
    host.idle(); // strobe idle levels follow the new strap
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check("reset data", ad_out, 8'h00);
    repeat (2) @(posedge clk);
  endtask

  task automatic t_bank();
    logic [7:0] a[3] = '{8'h00, 8'h3f, 8'hc1};
    for (int i = 0; i < 3; i++) host.wr(a[i], ~a[i], 1'b1);
    for (int i = 0; i < 3; i++) begin
      host.rd(a[i] ^ 8'h40, 1'b1, oe, d);
      check("read drive", {7'h0, oe}, 8'h01);
      check("read data", d, ~a[i]);
    end
  endtask

  task automatic t_select();
    host.wr(8'h05, 8'h22, 1'b1);
    host.wr(8'h05, 8'h11, 1'b0);
    host.rd(8'h05, 1'b0, oe, d);
    check("unselected drive", {7'h0, oe}, 8'h00);
    host.rd(8'h05, 1'b1, oe, d);
    check("unselected write", d, 8'h22);
  endtask

  task automatic t_style1();
    do_reset(1'b1);
    host.wr(8'h2a, 8'h96, 1'b1);
    host.wr(8'h15, 8'h69, 1'b1);
    host.rd(8'h2a, 1'b1, oe, d);
    check("strobe style data", d, 8'h96);
    host.rd(8'h15, 1'b1, oe, d);
    check("strobe style data", d, 8'h69);
  endtask

  task automatic t_float();
    @(posedge clk) #1 bp_clk = 1'b1;
    repeat (10) @(posedge clk);
    #1 check("float early", {7'h0, fl}, 8'h00);
    repeat (10) @(posedge clk);
    #1 check("float set", {7'h0, fl}, 8'h01);
    host.rd(8'h2a, 1'b1, oe, d);
    check("float drive", {7'h0, oe}, 8'h00);
    bp_clk = 1'b0;
    repeat (3) @(posedge clk);
    #1 check("float clear", {7'h0, fl}, 8'h00);
  endtask

  initial begin
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    bp_clk = 1'b0;
    do_reset(1'b0);
    t_bank();
    t_select();
    t_style1();
    t_float();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
